//--- include/mdr_pkg.sv
// shared constants and types for the motor diagnostics readback block
package mdr_pkg;

  // read-only register byte addresses
  localparam logic [7:0] ADDR_STATE_FLAGS = 8'h10;
  localparam logic [7:0] ADDR_SPEED_HIGH = 8'h11;
  localparam logic [7:0] ADDR_SPEED_LOW = 8'h12;
  localparam logic [7:0] ADDR_PERIOD_HIGH = 8'h13;
  localparam logic [7:0] ADDR_PERIOD_LOW = 8'h14;
  localparam logic [7:0] ADDR_EMF_HIGH = 8'h15;
  localparam logic [7:0] ADDR_EMF_LOW = 8'h16;
  localparam logic [7:0] ADDR_START_POS = 8'h19;
  localparam logic [7:0] ADDR_SUPPLY = 8'h1A;
  localparam logic [7:0] ADDR_INPUT_CMD = 8'h1B;
  localparam logic [7:0] ADDR_OUTPUT_DUTY = 8'h1C;

  // flag positions inside the state flags register; bits 3:0 read zero
  localparam int FLAG_THERMAL_BIT = 7;
  localparam int FLAG_SLEEP_BIT = 6;
  localparam int FLAG_CURRENT_BIT = 5;
  localparam int FLAG_STUCK_BIT = 4;

  // reset values and the saturated word value
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [15:0] WORD_SATURATED = 16'hFFFF;

  // timing: clock period and the 10 us period unit
  localparam int CLK_PERIOD_PS = 4000;
  localparam int PERIOD_UNIT_US = 10;
  localparam int PERIOD_UNIT_CYCLES = PERIOD_UNIT_US * 1000000 / CLK_PERIOD_PS;

  // speed word is ten times hertz, so speed = scale / (period in units)
  localparam int SPEED_SCALE = 10;
  localparam int SPEED_NUM = SPEED_SCALE * 1000000 / PERIOD_UNIT_US;
  localparam int DIV_STEPS = 20;

  // lock-off retry delay default, in microseconds
  localparam int LOCK_OFF_US_DFLT = 100;

  // start position codes for the six 60 degree sectors, 0 to 300 degrees
  localparam logic [7:0] SECTOR_CODE [6] = '{8'h00, 8'h2B, 8'h55, 8'h80, 8'hAB, 8'hD5};

  // open-loop tach select encoding; the fourth value behaves like drive
  typedef enum logic [1:0] {
    TACH_SEL_DRIVE,
    TACH_SEL_HIGH,
    TACH_SEL_FIRST,
    TACH_SEL_RSVD
  } mdr_tach_sel_e;

  // speed command source
  typedef enum logic [1:0] {
    CMD_SRC_PWM,
    CMD_SRC_ANALOG,
    CMD_SRC_SERIAL
  } mdr_cmd_src_e;

  typedef enum logic {
    LK_RUN,
    LK_HIZ
  } mdr_lock_e;

  // status inputs from the protection logic
  typedef struct packed {
    logic thermal;
    logic sleep;
    logic current;
    logic stuck;
  } mdr_flags_s;

  // events that move the tach output
  typedef struct packed {
    logic open_loop;
    logic drive_toggle;
    logic meas_toggle;
  } mdr_tach_ev_s;

endpackage : mdr_pkg

//--- rtl/mdr_tach_ctrl.sv
`timescale 1ns/1ns
// tach output generation for open loop, closed loop and lock
module mdr_tach_ctrl
  import mdr_pkg::*;
(
  input wire logic ref_clk, // core clock
  input wire logic rst_n, // async reset, active low
  input wire mdr_tach_ev_s tach_ev, // open-loop level and toggle pulses
  input wire logic locked, // rotor stuck condition present
  input wire logic [1:0] openloop_tach_select, // open-loop tach option
  output logic tach_out // tach output pin
);

  logic tach_r;
  logic tach_nxt;
  logic first_done_r;
  logic open_loop_d_r;
  wire open_loop_end;
  wire sel_hold;
  wire hold_high;
  wire toggle;

  // the first open-loop start since power-on ends when open loop falls
  assign open_loop_end = open_loop_d_r & ~tach_ev.open_loop;

  // options 1 and 2-after-first-start hold high; value 3 falls to drive
  assign sel_hold = (openloop_tach_select == TACH_SEL_HIGH)
    | ((openloop_tach_select == TACH_SEL_FIRST) & first_done_r);
  assign hold_high = locked | (tach_ev.open_loop & sel_hold);
  // open loop follows commanded drive frequency, closed loop the rotor
  assign toggle = tach_ev.open_loop ? tach_ev.drive_toggle : tach_ev.meas_toggle;
  assign tach_nxt = hold_high ? 1'b1 : (toggle ? ~tach_r : tach_r);

  // first start memory lasts until the next power-on reset
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tach_r <= 1'b1;
      first_done_r <= 1'b0;
      open_loop_d_r <= 1'b0;
    end
    else
    begin
      tach_r <= tach_nxt;
      first_done_r <= first_done_r | open_loop_end;
      open_loop_d_r <= tach_ev.open_loop;
    end
  end

  assign tach_out = tach_r;

endmodule : mdr_tach_ctrl

//--- rtl/mdr_diag_readback.sv
`timescale 1ns/1ns
module mdr_diag_readback
  import mdr_pkg::*;
#(
  parameter int LOCK_OFF_US = LOCK_OFF_US_DFLT
)
(
  input wire logic ref_clk, // core clock, 250 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic rd_en, // one-cycle register read strobe
  input wire logic [7:0] rd_addr, // register byte address
  output logic [7:0] rd_data, // read data, valid with rd_valid
  output logic rd_valid, // one-cycle read answer
  input wire mdr_flags_s flags_in, // protection status levels
  input wire logic lock_current_over, // lock current threshold exceeded
  output logic phases_hiz, // output phases tri-stated
  input wire logic motor_running, // motor is being driven
  input wire logic zc_u_rise, // phase u rising zero crossing pulse
  input wire logic zc_u_fall, // phase u falling zero crossing pulse
  input wire logic bemf_valid, // back-emf sample strobe
  input wire logic [15:0] bemf_sample, // back-emf sample, word-scaled
  input wire logic sense_done, // position sensing finished pulse
  input wire logic [2:0] sense_sector, // detected sector 0..5
  input wire logic [7:0] sense_adv, // advance angle code
  input wire logic supply_valid, // supply conversion strobe
  input wire logic [7:0] supply_code, // supply conversion result
  input wire logic [1:0] cmd_source, // speed input source
  input wire logic [7:0] pwm_duty_code, // speed from pwm duty
  input wire logic [7:0] analog_code, // speed from analog level
  input wire logic [7:0] serial_code, // speed from serial bus
  input wire logic [7:0] out_duty_code, // limited output duty
  input wire logic [1:0] openloop_tach_select, // open-loop tach option
  input wire mdr_tach_ev_s tach_ev, // tach events
  output logic tach_out // tach output pin
);

  localparam int LOCK_OFF_CYCLES = LOCK_OFF_US * 1000000 / CLK_PERIOD_PS;
  localparam int LW = $clog2(LOCK_OFF_CYCLES + 1);
  localparam int UW = $clog2(PERIOD_UNIT_CYCLES + 1);

  // lock-off retry state
  mdr_lock_e lock_st_r;
  mdr_lock_e lock_st_nxt;
  logic [LW-1:0] lock_cnt_r;
  logic stuck_r;
  logic hiz_r;

  // measurement state
  logic [UW-1:0] unit_cnt_r;
  logic [15:0] period_cnt_r;
  logic [15:0] period_r;
  logic [15:0] speed_r;
  logic [23:0] emf_acc_r;
  logic in_half_r;
  logic [15:0] emf_r;
  logic [7:0] position_r;
  logic [7:0] supply_r;
  logic [7:0] cmd_r;
  logic [7:0] duty_r;

  // divider state
  logic div_busy_r;
  logic [4:0] div_step_r;
  logic [19:0] div_dvd_r;
  logic [16:0] div_rem_r;
  logic [15:0] div_den_r;

  // read port state
  logic [7:0] shadow_r;
  logic [7:0] rd_data_r;
  logic rd_valid_r;

  // lock handling: float phases, keep flag until the retry
  wire lock_done = (lock_cnt_r == LW'(LOCK_OFF_CYCLES - 1));
  wire lock_enter = (lock_st_r == LK_RUN) & lock_current_over;

  always_comb
  begin
    lock_st_nxt = lock_st_r;
    case (lock_st_r)
      LK_RUN: if (lock_current_over) lock_st_nxt = LK_HIZ;
      LK_HIZ: if (lock_done) lock_st_nxt = LK_RUN;
      default: lock_st_nxt = LK_RUN;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lock_st_r <= LK_RUN;
      lock_cnt_r <= '0;
      stuck_r <= 1'b0;
      hiz_r <= 1'b0;
    end
    else
    begin
      lock_st_r <= lock_st_nxt;
      lock_cnt_r <= (lock_st_r == LK_HIZ) ? lock_cnt_r + 1'b1 : '0;
      stuck_r <= lock_enter | (stuck_r & ~((lock_st_r == LK_HIZ) & lock_done));
      hiz_r <= (lock_st_nxt == LK_HIZ);
    end
  end

  wire locked = stuck_r | flags_in.stuck;

  // period count in 10 us units, saturating so a slow rotor reads full scale
  wire unit_tick = (unit_cnt_r == UW'(PERIOD_UNIT_CYCLES - 1));
  wire capture = zc_u_rise & motor_running;
  wire period_sat = (period_cnt_r == WORD_SATURATED);

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      unit_cnt_r <= '0;
      period_cnt_r <= RESET_WORD;
      period_r <= RESET_WORD;
    end
    else
    begin
      unit_cnt_r <= (zc_u_rise | unit_tick) ? '0 : unit_cnt_r + 1'b1;
      if (zc_u_rise)
        period_cnt_r <= RESET_WORD;
      else if (unit_tick & ~period_sat)
        period_cnt_r <= period_cnt_r + 16'h0001;
      if (capture & (period_cnt_r != RESET_WORD))
        period_r <= period_cnt_r;
    end
  end

  // speed = scale / period by a restoring divider, one bit per cycle;
  // a crossing during a division restarts it with the newer period
  wire div_start = capture & (period_cnt_r != RESET_WORD);
  wire [16:0] div_trial = {div_rem_r[15:0], div_dvd_r[19]};
  wire div_fits = (div_trial >= {1'b0, div_den_r});
  wire [16:0] div_rem_nxt = div_fits ? div_trial - {1'b0, div_den_r} : div_trial;
  wire [19:0] div_q_nxt = {div_dvd_r[18:0], div_fits};
  wire div_last = (div_step_r == 5'(DIV_STEPS - 1));
  wire [15:0] speed_nxt = (div_q_nxt[19:16] != 4'h0) ? WORD_SATURATED : div_q_nxt[15:0];

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_busy_r <= 1'b0;
      div_step_r <= 5'h00;
      div_dvd_r <= 20'h00000;
      div_rem_r <= 17'h00000;
      div_den_r <= RESET_WORD;
      speed_r <= RESET_WORD;
    end
    else if (div_start)
    begin
      div_busy_r <= 1'b1;
      div_step_r <= 5'h00;
      div_dvd_r <= 20'(SPEED_NUM);
      div_rem_r <= 17'h00000;
      div_den_r <= period_cnt_r;
    end
    else if (div_busy_r)
    begin
      div_step_r <= div_step_r + 5'h01;
      div_dvd_r <= div_q_nxt;
      div_rem_r <= div_rem_nxt;
      div_busy_r <= ~div_last;
      if (div_last)
        speed_r <= speed_nxt;
    end
  end

  // emf integrated from rising to falling crossing, stored once per cycle
  wire [23:0] emf_sum = emf_acc_r + {8'h00, bemf_sample};
  wire [15:0] emf_word = (emf_acc_r[23:16] != 8'h00) ? WORD_SATURATED : emf_acc_r[15:0];

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      emf_acc_r <= 24'h000000;
      in_half_r <= 1'b0;
      emf_r <= RESET_WORD;
    end
    else
    begin
      if (zc_u_rise)
        emf_acc_r <= 24'h000000;
      else if (bemf_valid & in_half_r)
        emf_acc_r <= emf_sum;
      in_half_r <= zc_u_rise | (in_half_r & ~zc_u_fall);
      if (zc_u_fall & in_half_r & motor_running)
        emf_r <= emf_word;
    end
  end

  // position code, supply level and speed commands
  wire [2:0] sector_idx = (sense_sector > 3'h5) ? 3'h5 : sense_sector;
  wire [7:0] position_nxt = SECTOR_CODE[sector_idx] + sense_adv;
  wire [7:0] cmd_nxt = (cmd_source == CMD_SRC_ANALOG) ? analog_code :
    (cmd_source == CMD_SRC_SERIAL) ? serial_code : pwm_duty_code;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      position_r <= RESET_BYTE;
      supply_r <= RESET_BYTE;
      cmd_r <= RESET_BYTE;
      duty_r <= RESET_BYTE;
    end
    else
    begin
      if (sense_done)
        position_r <= position_nxt;
      if (supply_valid & motor_running)
        supply_r <= supply_code;
      cmd_r <= cmd_nxt;
      duty_r <= out_duty_code;
    end
  end

  // register read decode; the low byte of a pair comes from the shadow
  wire [7:0] flags_byte;
  assign flags_byte[FLAG_THERMAL_BIT] = flags_in.thermal;
  assign flags_byte[FLAG_SLEEP_BIT] = flags_in.sleep;
  assign flags_byte[FLAG_CURRENT_BIT] = flags_in.current;
  assign flags_byte[FLAG_STUCK_BIT] = locked;
  assign flags_byte[3:0] = 4'h0;

  wire hit_spd_hi = (rd_addr == ADDR_SPEED_HIGH);
  wire hit_per_hi = (rd_addr == ADDR_PERIOD_HIGH);
  wire hit_emf_hi = (rd_addr == ADDR_EMF_HIGH);
  wire hit_high = hit_spd_hi | hit_per_hi | hit_emf_hi;
  wire hit_low = (rd_addr == ADDR_SPEED_LOW) | (rd_addr == ADDR_PERIOD_LOW)
    | (rd_addr == ADDR_EMF_LOW);
  wire [7:0] low_snap = hit_spd_hi ? speed_r[7:0] : hit_per_hi ? period_r[7:0] : emf_r[7:0];

  wire [7:0] rd_sel = (rd_addr == ADDR_STATE_FLAGS) ? flags_byte :
    hit_spd_hi ? speed_r[15:8] :
    hit_per_hi ? period_r[15:8] :
    hit_emf_hi ? emf_r[15:8] :
    hit_low ? shadow_r :
    (rd_addr == ADDR_START_POS) ? position_r :
    (rd_addr == ADDR_SUPPLY) ? supply_r :
    (rd_addr == ADDR_INPUT_CMD) ? cmd_r :
    (rd_addr == ADDR_OUTPUT_DUTY) ? duty_r : RESET_BYTE;

  // reads answer one cycle later; unmapped addresses read zero
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shadow_r <= RESET_BYTE;
      rd_data_r <= RESET_BYTE;
      rd_valid_r <= 1'b0;
    end
    else
    begin
      if (rd_en & hit_high)
        shadow_r <= low_snap;
      if (rd_en)
        rd_data_r <= rd_sel;
      rd_valid_r <= rd_en;
    end
  end

  mdr_tach_ctrl u_tach (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .tach_ev(tach_ev),
    .locked(locked),
    .openloop_tach_select(openloop_tach_select),
    .tach_out(tach_out)
  );

  assign rd_data = rd_data_r;
  assign rd_valid = rd_valid_r;
  assign phases_hiz = hiz_r;

endmodule : mdr_diag_readback

//--- test/mdr_props.sv
`timescale 1ns/1ns
// port-level checks of the readback block
module mdr_props
  import mdr_pkg::*;
#(
  parameter int LOCK_OFF_US = LOCK_OFF_US_DFLT
)
(
  input wire logic ref_clk, // core clock
  input wire logic rst_n, // async reset, active low
  input wire logic rd_en, // read strobe
  input wire logic [7:0] rd_addr, // read address
  input wire logic [7:0] rd_data, // read data
  input wire logic rd_valid, // read answer
  input wire mdr_flags_s flags_in, // status levels
  input wire logic lock_current_over, // lock trip
  input wire logic phases_hiz, // phases floated
  input wire logic [1:0] cmd_source, // command source
  input wire logic [7:0] serial_code, // serial command
  input wire logic [1:0] openloop_tach_select, // tach option
  input wire mdr_tach_ev_s tach_ev, // tach events
  input wire logic tach_out // tach pin
);
  localparam int LOCK_CYC = LOCK_OFF_US * 250;
  logic [31:0] hiz_cnt_r;
  logic [31:0] hiz_cnt_nxt;
  logic quiet;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // floated-cycle count; a retry one cycle early or late shows here
  assign hiz_cnt_nxt = phases_hiz ? hiz_cnt_r + 32'h1 : 32'h0;
  assign quiet = !phases_hiz && !flags_in.stuck;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n) hiz_cnt_r <= 32'h0;
    else hiz_cnt_r <= hiz_cnt_nxt;
  end

  property p_rd_answer; rd_en |=> rd_valid; endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read got no answer");
  property p_flags; rd_en && rd_addr == ADDR_STATE_FLAGS && quiet && $stable(flags_in)
    |=> rd_data == {$past(flags_in[3:1]), 5'h00}; endproperty
  a_flags: assert property (p_flags)
    else $error("status byte wrong");
  property p_lock_set; lock_current_over && !phases_hiz |=> phases_hiz; endproperty
  a_lock_set: assert property (p_lock_set)
    else $error("lock did not float phases");
  property p_lock_len; $fell(phases_hiz) |-> hiz_cnt_r == LOCK_CYC; endproperty
  a_lock_len: assert property (p_lock_len)
    else $error("lock-off length wrong");
  property p_lock_tach; phases_hiz |=> tach_out; endproperty
  a_lock_tach: assert property (p_lock_tach)
    else $error("tach not high in lock");
  property p_hold_high; tach_ev.open_loop && openloop_tach_select == TACH_SEL_HIGH
    |=> tach_out; endproperty
  a_hold_high: assert property (p_hold_high)
    else $error("tach not held high");
  property p_drive; quiet && $past(quiet) && tach_ev.open_loop && tach_ev.drive_toggle
    && openloop_tach_select inside {TACH_SEL_DRIVE, TACH_SEL_RSVD}
    |=> tach_out != $past(tach_out); endproperty
  a_drive: assert property (p_drive)
    else $error("tach did not follow drive");
  property p_cmd; rd_en && rd_addr == ADDR_INPUT_CMD && cmd_source == CMD_SRC_SERIAL
    && $stable(serial_code) && $stable(cmd_source) |=> rd_data == $past(serial_code);
  endproperty
  a_cmd: assert property (p_cmd)
    else $error("command readback wrong");
endmodule : mdr_props

bind mdr_diag_readback mdr_props #(.LOCK_OFF_US(LOCK_OFF_US)) props_u (
  .ref_clk(ref_clk), .rst_n(rst_n), .rd_en(rd_en), .rd_addr(rd_addr),
  .rd_data(rd_data), .rd_valid(rd_valid), .flags_in(flags_in),
  .lock_current_over(lock_current_over), .phases_hiz(phases_hiz),
  .cmd_source(cmd_source), .serial_code(serial_code),
  .openloop_tach_select(openloop_tach_select), .tach_ev(tach_ev), .tach_out(tach_out));

//--- test/mdr_host_model.sv
`timescale 1ns/1ns
// host on the read port: one read at a time, quick or slow
module mdr_host_model
(
  input wire logic ref_clk, // core clock
  output logic rd_en, // read strobe
  output logic [7:0] rd_addr, // read address
  input wire logic rd_valid, // read answer
  input wire logic [7:0] rd_data // read data
);
  initial
  begin
    rd_en = 1'b0;
    rd_addr = 8'h00;
  end

  // the address is inverted after use so a stale value never helps
  task automatic rd(input logic [7:0] a, input int gap, output logic [7:0] d);
    int n;
    n = 0;
    repeat (gap) @(posedge ref_clk);
    @(posedge ref_clk);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    rd_addr <= ~a;
    #1;
    while (rd_valid !== 1'b1 && n < 8)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    d = (n < 8) ? rd_data : 8'hXX;
  endtask : rd

  // high byte first so the low byte comes from the snapshot
  task automatic rd_pair(input logic [7:0] a, output logic [15:0] w);
    rd(a, 1, w[15:8]);
    rd(a + 8'h01, 0, w[7:0]);
  endtask : rd_pair
endmodule : mdr_host_model

//--- test/testbench.sv
`timescale 1ns/1ns
// register-level tests of the diagnostics readback block
module testbench
  import mdr_pkg::*;
;
  localparam int LOCK_US = 1;
  localparam int LOCK_CYC = LOCK_US * 250;
  localparam int MAX_CYC = 80000; // sequence needs about 51k cycles
  logic ref_clk, rst_n, rd_en, rd_valid, lock_current_over, phases_hiz, motor_running;
  logic zc_u_rise, zc_u_fall, bemf_valid, sense_done, supply_valid, tach_out;
  logic [7:0] rd_addr, rd_data, sense_adv, supply_code, pwm_duty_code, analog_code;
  logic [7:0] serial_code, out_duty_code;
  logic [15:0] bemf_sample, w;
  logic [2:0] sense_sector;
  logic [1:0] cmd_source, openloop_tach_select;
  logic [5:0] t;
  mdr_flags_s flags_in;
  mdr_tach_ev_s tach_ev;
  int fails, checks, cyc;
  logic [7:0] sect [6] = '{8'h00, 8'h2B, 8'h55, 8'h80, 8'hAB, 8'hD5};
  // {open_loop, drive, meas, select, expected tach}
  logic [5:0] tach_tab [7] = '{6'h34, 6'h0D, 6'h30, 6'h23, 6'h36, 6'h25, 6'h08};

  mdr_diag_readback #(.LOCK_OFF_US(LOCK_US)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
    .flags_in(flags_in), .lock_current_over(lock_current_over), .phases_hiz(phases_hiz),
    .motor_running(motor_running), .zc_u_rise(zc_u_rise), .zc_u_fall(zc_u_fall),
    .bemf_valid(bemf_valid), .bemf_sample(bemf_sample), .sense_done(sense_done),
    .sense_sector(sense_sector), .sense_adv(sense_adv), .supply_valid(supply_valid),
    .supply_code(supply_code), .cmd_source(cmd_source), .pwm_duty_code(pwm_duty_code),
    .analog_code(analog_code), .serial_code(serial_code), .out_duty_code(out_duty_code),
    .openloop_tach_select(openloop_tach_select), .tach_ev(tach_ev), .tach_out(tach_out));
  mdr_host_model host_u (.ref_clk(ref_clk), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_valid(rd_valid), .rd_data(rd_data));

  initial ref_clk = 1'b0;
  always #2 ref_clk = ~ref_clk;

  task final_report;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    host_u.rd(a, 2, v);
    chk(v, exp);
  endtask : rdc

  // a hang ends the run through the same report
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == MAX_CYC)
    begin
      fails++;
      final_report();
    end
  end

  initial
  begin
    {rst_n, lock_current_over, zc_u_rise, zc_u_fall, bemf_valid, sense_done} = '0;
    {supply_valid, sense_sector, sense_adv, supply_code, bemf_sample} = '0;
    {cmd_source, openloop_tach_select, flags_in, tach_ev} = '0;
    {motor_running, pwm_duty_code, analog_code} = {1'b1, 8'h1F, 8'h22};
    {serial_code, out_duty_code, fails, checks, cyc} = {8'hE1, 8'hFF, 32'h0, 32'h0, 32'h0};
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdc(ADDR_STATE_FLAGS, 8'h00);
    // tach options, first start after reset included
    for (int i = 0; i < 7; i++)
    begin
      t = tach_tab[i];
      @(posedge ref_clk);
      tach_ev <= t[5:3];
      openloop_tach_select <= t[2:1];
      @(posedge ref_clk);
      tach_ev <= {t[5], 2'b00};
      repeat (2) @(posedge ref_clk);
      tach_ev <= 3'b000;
      // look after the edge's update has settled, not in its own time step
      #1;
      chk({7'h0, tach_out}, {7'h0, t[0]});
    end
    @(posedge ref_clk);
    flags_in <= 4'b1110;
    rdc(ADDR_STATE_FLAGS, 8'hE0);
    // lock while tach is low, so the forced high is visible
    @(posedge ref_clk);
    flags_in <= 4'b0000;
    lock_current_over <= 1'b1;
    @(posedge ref_clk);
    lock_current_over <= 1'b0;
    #1;
    chk({7'h0, phases_hiz}, 8'h01);
    rdc(ADDR_STATE_FLAGS, 8'h10);
    chk({7'h0, tach_out}, 8'h01);
    repeat (LOCK_CYC - 20) @(posedge ref_clk);
    chk({7'h0, phases_hiz}, 8'h01);
    repeat (30) @(posedge ref_clk);
    chk({7'h0, phases_hiz}, 8'h00);
    rdc(ADDR_STATE_FLAGS, 8'h00);
    for (int s = 0; s < 6; s++)
    begin
      @(posedge ref_clk);
      {sense_done, sense_sector, sense_adv} <= {1'b1, 3'(s), 8'h2C};
      @(posedge ref_clk);
      sense_done <= 1'b0;
      rdc(ADDR_START_POS, sect[s] + 8'h2C);
    end
    // the second sample comes while stopped and must be ignored
    @(posedge ref_clk);
    {supply_valid, supply_code} <= {1'b1, 8'hA5};
    @(posedge ref_clk);
    {supply_code, motor_running} <= {8'h5A, 1'b0};
    @(posedge ref_clk);
    {supply_valid, motor_running} <= 2'b01;
    rdc(ADDR_SUPPLY, 8'hA5);
    for (int c = 0; c < 4; c++)
    begin
      @(posedge ref_clk);
      cmd_source <= c[1:0];
      rdc(ADDR_INPUT_CMD, c == 1 ? 8'h22 : c == 2 ? 8'hE1 : 8'h1F);
    end
    rdc(ADDR_OUTPUT_DUTY, 8'hFF);
    // one electrical cycle of 20 period units, with two back-emf samples
    @(posedge ref_clk);
    zc_u_rise <= 1'b1;
    @(posedge ref_clk);
    {zc_u_rise, bemf_valid, bemf_sample} <= {2'b01, 16'h1234};
    @(posedge ref_clk);
    bemf_sample <= 16'h0100;
    @(posedge ref_clk);
    {bemf_valid, zc_u_fall} <= 2'b01;
    @(posedge ref_clk);
    zc_u_fall <= 1'b0;
    repeat (20 * 2500) @(posedge ref_clk);
    zc_u_rise <= 1'b1;
    @(posedge ref_clk);
    zc_u_rise <= 1'b0;
    repeat (30) @(posedge ref_clk);
    host_u.rd_pair(ADDR_SPEED_HIGH, w);
    chk(w[15:8], 8'hC3);
    chk(w[7:0], 8'h50);
    host_u.rd_pair(ADDR_PERIOD_HIGH, w);
    chk(w[15:8], 8'h00);
    chk(w[7:0], 8'h14);
    host_u.rd_pair(ADDR_EMF_HIGH, w);
    chk(w[15:8], 8'h13);
    chk(w[7:0], 8'h34);
    rdc(ADDR_SPEED_HIGH, 8'hC3);
    rdc(ADDR_PERIOD_LOW, 8'h50);
    final_report();
  end
endmodule : testbench
